// ### hw/bfp_pkg.sv
// Constants and types for the bidirectional queue port controller.
// Assumes one system clock; both port clocks arrive as sampled pins.
package bfp_pkg;
  localparam logic [7:0] REG_AE_AB    = 8'h00;
  localparam logic [7:0] REG_AE_BA    = 8'h04;
  localparam logic [7:0] REG_AF_AB    = 8'h08;
  localparam logic [7:0] REG_AF_BA    = 8'h0C;
  localparam logic [7:0] REG_STATUS   = 8'h10;
  localparam logic [7:0] REG_COUNT    = 8'h14;
  localparam logic [7:0] REG_IRQ_STAT = 8'h18;
  localparam logic [7:0] REG_IRQ_CLR  = 8'h1C;
  localparam logic [7:0] REG_IRQ_EN   = 8'h20;

  localparam logic [6:0] THR_8    = 7'h08;
  localparam logic [6:0] THR_16   = 7'h10;
  localparam logic [6:0] THR_64   = 7'h40;
  localparam logic [6:0] THR_PROG = 7'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        port_a_clk;
    logic        port_b_clk;
    logic        a_wr;
    logic        a_rd;
    logic        b_wr;
    logic        b_rd;
    logic        endian_or_fall;
    logic        narrow;
    logic        size;
    logic        flag_select_hi;
    logic        flag_select_lo;
    logic [35:0] a_data;
    logic [35:0] b_data;
  } bfp_pins_t;
endpackage

// ### hw/bfp_top.sv
// Bidirectional queue port controller: two queues, flags, bus matching, AXI4-Lite.
// Assumes all port and strap pins are asynchronous and that aresetn is held low for 3 or more edges.
`timescale 1ns/1ps
`default_nettype none
module bfp_top #(
  parameter int DEPTH = 256
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        port_a_clk,
  input  wire logic        port_b_clk,
  input  wire logic        port_a_wr_en,
  input  wire logic        port_a_rd_en,
  input  wire logic        port_b_wr_en,
  input  wire logic        port_b_rd_en,
  input  wire logic        endian_or_fall_through_sel,
  input  wire logic        port_b_narrow_width_sel,
  input  wire logic        port_b_size_sel,
  input  wire logic        flag_select_hi,
  input  wire logic        flag_select_lo,
  input  wire logic [35:0] port_a_data_bus_in,
  output logic      [35:0] port_a_data_bus_out,
  output logic             port_a_data_bus_oe,
  input  wire logic [35:0] port_b_data_bus_in,
  output logic      [35:0] port_b_data_bus_out,
  output logic             port_b_data_bus_oe,
  output logic             port_a_full_or_input_ready,
  output logic             port_a_empty_or_output_ready,
  output logic             port_a_near_full_flag,
  output logic             port_a_near_empty_flag,
  output logic             port_b_full_or_input_ready,
  output logic             port_b_empty_or_output_ready,
  output logic             port_b_near_full_flag,
  output logic             port_b_near_empty_flag,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  // Flag vectors: [3] near empty, [2] near full, [1] empty or ready, [0] space.
  typedef struct packed {
    bfp_pkg::bfp_pins_t p1;
    bfp_pkg::bfp_pins_t p2;
    logic          port_a_clk_d;
    logic          port_b_clk_d;
    logic          big;
    logic [CW-1:0] wab;
    logic [CW-1:0] rab;
    logic [CW-1:0] wba;
    logic [CW-1:0] rba;
    logic [CW-1:0] a_to_b_empty_threshold;
    logic [CW-1:0] b_to_a_empty_threshold;
    logic [CW-1:0] a_to_b_full_threshold;
    logic [CW-1:0] b_to_a_full_threshold;
    logic          ova;
    logic          vb;
    logic [1:0]    kr;
    logic [1:0]    kw;
    logic [35:0]   oa;
    logic [35:0]   ob;
    logic [35:0]   hb;
    logic [35:0]   acc;
    logic          oea;
    logic          oeb;
    logic [3:0]    fa1;
    logic [3:0]    fa2;
    logic [3:0]    fb1;
    logic [3:0]    fb2;
    logic [3:0]    irq_stat;
    logic [3:0]    irq_en;
    logic          irq;
    logic          aw_got;
    logic          w_got;
    logic [7:0]    awaddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
  } bfp_state_t;

  bfp_state_t         s_r;
  bfp_state_t         s_nxt;
  bfp_pkg::bfp_pins_t pins;
  logic [35:0]        mem_ab [DEPTH];
  logic [35:0]        mem_ba [DEPTH];
  logic               push_ab;
  logic               push_ba;
  logic [35:0]        din_ba;
  logic               ea;
  logic               eb;
  logic               fall_through_sel;
  logic [1:0]         lst;
  logic [CW-1:0]      cnt_ab;
  logic [CW-1:0]      cnt_ba;
  logic [CW-1:0]      free_ab;
  logic [CW-1:0]      free_ba;
  logic [CW-1:0]      thr_def;
  logic [3:0]         clr;
  logic [3:0]         ev;
  logic [35:0]        head_ab;

  function automatic logic [1:0] last_idx(input logic nar, input logic sz);
    last_idx = !nar ? 2'd0 : (sz ? 2'd3 : 2'd1);
  endfunction

  function automatic logic [1:0] pos_of(input logic [1:0] k, input logic [1:0] l,
                                        input logic big);
    pos_of = big ? l - k : k;
  endfunction

  function automatic logic [35:0] piece_of(input logic [35:0] w, input logic [1:0] pos,
                                           input logic nar, input logic sz);
    if (!nar) begin
      piece_of = w;
    end else if (sz) begin
      piece_of = {27'h000_0000, w[9*pos +: 9]};
    end else begin
      piece_of = {18'h0_0000, w[18*pos[0] +: 18]};
    end
  endfunction

  function automatic logic [35:0] put_piece(input logic [35:0] acc, input logic [35:0] d,
                                            input logic [1:0] pos, input logic nar,
                                            input logic sz);
    logic [35:0] r;
    r = acc;
    if (!nar) begin
      r = d;
    end else if (sz) begin
      r[9*pos +: 9] = d[8:0];
    end else begin
      r[18*pos[0] +: 18] = d[17:0];
    end
    put_piece = r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] stb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (stb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  assign pins = '{port_a_clk, port_b_clk, port_a_wr_en, port_a_rd_en, port_b_wr_en,
                  port_b_rd_en, endian_or_fall_through_sel, port_b_narrow_width_sel,
                  port_b_size_sel, flag_select_hi, flag_select_lo,
                  port_a_data_bus_in, port_b_data_bus_in};
  assign head_ab = mem_ab[s_r.rab[AW-1:0]];

  always_comb begin
    s_nxt = s_r;
    push_ab = 1'b0;
    push_ba = 1'b0;
    din_ba = put_piece(s_r.acc, s_r.p2.b_data, 2'd0, 1'b0, 1'b0);
    clr = 4'h0;
    s_nxt.p1 = pins;
    s_nxt.p2 = s_r.p1;
    s_nxt.port_a_clk_d = s_r.p2.port_a_clk;
    s_nxt.port_b_clk_d = s_r.p2.port_b_clk;
    ea = s_r.p2.port_a_clk & ~s_r.port_a_clk_d;
    eb = s_r.p2.port_b_clk & ~s_r.port_b_clk_d;
    fall_through_sel = ~s_r.p2.endian_or_fall;
    lst = last_idx(s_r.p2.narrow, s_r.p2.size);
    cnt_ab = s_r.wab - s_r.rab;
    cnt_ba = s_r.wba - s_r.rba;
    free_ab = DEPTH_C - cnt_ab;
    free_ba = DEPTH_C - cnt_ba;

    if (ea && s_r.p2.a_wr && free_ab != '0) begin
      push_ab = 1'b1;
      s_nxt.wab = s_r.wab + 1'b1;
    end
    if (fall_through_sel) begin
      if (ea && s_r.p2.a_rd && s_r.ova) begin
        s_nxt.ova = 1'b0;
      end else if (!s_r.ova && cnt_ba != '0) begin
        s_nxt.oa = mem_ba[s_r.rba[AW-1:0]];
        s_nxt.ova = 1'b1;
        s_nxt.rba = s_r.rba + 1'b1;
      end
    end else if (ea && s_r.p2.a_rd && cnt_ba != '0) begin
      s_nxt.oa = mem_ba[s_r.rba[AW-1:0]];
      s_nxt.rba = s_r.rba + 1'b1;
    end

    if (fall_through_sel && !s_r.vb && cnt_ab != '0) begin
      s_nxt.hb = head_ab;
      s_nxt.vb = 1'b1;
      s_nxt.kr = 2'd0;
      s_nxt.rab = s_r.rab + 1'b1;
      s_nxt.ob = piece_of(head_ab, pos_of(2'd0, lst, s_r.big), s_r.p2.narrow, s_r.p2.size);
    end else if (fall_through_sel && eb && s_r.p2.b_rd && s_r.vb) begin
      if (s_r.kr == lst) begin
        s_nxt.vb = 1'b0;
      end else begin
        s_nxt.kr = s_r.kr + 2'd1;
        s_nxt.ob = piece_of(s_r.hb, pos_of(s_r.kr + 2'd1, lst, s_r.big),
                            s_r.p2.narrow, s_r.p2.size);
      end
    end else if (!fall_through_sel && eb && s_r.p2.b_rd) begin
      if (s_r.vb) begin
        s_nxt.ob = piece_of(s_r.hb, pos_of(s_r.kr, lst, s_r.big),
                            s_r.p2.narrow, s_r.p2.size);
        s_nxt.vb = s_r.kr != lst;
        s_nxt.kr = s_r.kr + 2'd1;
      end else if (cnt_ab != '0) begin
        s_nxt.hb = head_ab;
        s_nxt.rab = s_r.rab + 1'b1;
        s_nxt.ob = piece_of(head_ab, pos_of(2'd0, lst, s_r.big),
                            s_r.p2.narrow, s_r.p2.size);
        s_nxt.vb = lst != 2'd0;
        s_nxt.kr = 2'd1;
      end
    end

    if (eb && s_r.p2.b_wr && free_ba != '0) begin
      din_ba = put_piece(s_r.acc, s_r.p2.b_data, pos_of(s_r.kw, lst, s_r.big),
                         s_r.p2.narrow, s_r.p2.size);
      s_nxt.acc = din_ba;
      if (s_r.kw == lst) begin
        push_ba = 1'b1;
        s_nxt.kw = 2'd0;
        s_nxt.wba = s_r.wba + 1'b1;
      end else begin
        s_nxt.kw = s_r.kw + 2'd1;
      end
    end

    s_nxt.oea = s_r.p2.a_rd;
    s_nxt.oeb = s_r.p2.b_rd;
    if (ea) begin
      s_nxt.fa1 = {cnt_ba > s_r.b_to_a_empty_threshold, free_ab > s_r.a_to_b_full_threshold,
                   fall_through_sel ? s_r.ova : cnt_ba != '0, free_ab != '0};
      s_nxt.fa2 = s_r.fa1;
    end
    if (eb) begin
      s_nxt.fb1 = {cnt_ab > s_r.a_to_b_empty_threshold, free_ba > s_r.b_to_a_full_threshold,
                   fall_through_sel ? s_r.vb : (s_r.vb | cnt_ab != '0), free_ba != '0};
      s_nxt.fb2 = s_r.fb1;
    end
    ev = {s_r.fb2[3:2] & ~s_nxt.fb2[3:2], s_r.fa2[2] & ~s_nxt.fa2[2],
          s_r.fa2[3] & ~s_nxt.fa2[3]};

    if (s_r.awready && s_axi_awvalid) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_r.wready && s_axi_wvalid) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = bfp_pkg::RESP_OKAY;
      unique case (s_r.awaddr)
        bfp_pkg::REG_AE_AB: s_nxt.a_to_b_empty_threshold =
          CW'(merge(32'(s_r.a_to_b_empty_threshold), s_r.wdata, s_r.wstrb));
        bfp_pkg::REG_AE_BA: s_nxt.b_to_a_empty_threshold =
          CW'(merge(32'(s_r.b_to_a_empty_threshold), s_r.wdata, s_r.wstrb));
        bfp_pkg::REG_AF_AB: s_nxt.a_to_b_full_threshold =
          CW'(merge(32'(s_r.a_to_b_full_threshold), s_r.wdata, s_r.wstrb));
        bfp_pkg::REG_AF_BA: s_nxt.b_to_a_full_threshold =
          CW'(merge(32'(s_r.b_to_a_full_threshold), s_r.wdata, s_r.wstrb));
        bfp_pkg::REG_IRQ_CLR: clr = s_r.wdata[3:0] & {4{s_r.wstrb[0]}};
        bfp_pkg::REG_IRQ_EN: s_nxt.irq_en = 4'(merge(32'(s_r.irq_en), s_r.wdata, s_r.wstrb));
        bfp_pkg::REG_STATUS, bfp_pkg::REG_COUNT, bfp_pkg::REG_IRQ_STAT: ;
        default: s_nxt.bresp = bfp_pkg::RESP_SLVERR;
      endcase
    end
    s_nxt.awready = !s_nxt.aw_got;
    s_nxt.wready = !s_nxt.w_got;

    if (s_r.arready && s_axi_arvalid) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = bfp_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        bfp_pkg::REG_AE_AB: s_nxt.rdata = 32'(s_r.a_to_b_empty_threshold);
        bfp_pkg::REG_AE_BA: s_nxt.rdata = 32'(s_r.b_to_a_empty_threshold);
        bfp_pkg::REG_AF_AB: s_nxt.rdata = 32'(s_r.a_to_b_full_threshold);
        bfp_pkg::REG_AF_BA: s_nxt.rdata = 32'(s_r.b_to_a_full_threshold);
        bfp_pkg::REG_STATUS: s_nxt.rdata = {20'h0_0000, s_r.fb2, s_r.fa2, s_r.p2.size,
                                            s_r.p2.narrow, fall_through_sel, s_r.big};
        bfp_pkg::REG_COUNT: s_nxt.rdata = {16'(cnt_ba), 16'(cnt_ab)};
        bfp_pkg::REG_IRQ_STAT: s_nxt.rdata = {28'h000_0000, s_r.irq_stat};
        bfp_pkg::REG_IRQ_EN: s_nxt.rdata = {28'h000_0000, s_r.irq_en};
        bfp_pkg::REG_IRQ_CLR: s_nxt.rdata = 32'h0000_0000;
        default: begin
          s_nxt.rdata = 32'h0000_0000;
          s_nxt.rresp = bfp_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end

    // An event in the clearing cycle survives, so the set is applied last.
    s_nxt.irq_stat = (s_r.irq_stat & ~clr) | ev;
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_en);

    unique case ({s_r.p2.flag_select_hi, s_r.p2.flag_select_lo})
      2'b01: thr_def = CW'(bfp_pkg::THR_8);
      2'b10: thr_def = CW'(bfp_pkg::THR_16);
      2'b11: thr_def = CW'(bfp_pkg::THR_64);
      2'b00: thr_def = CW'(bfp_pkg::THR_PROG);
    endcase
    // The straps keep flowing through the samplers so reset can capture them.
    if (!aresetn) begin
      s_nxt = '0;
      s_nxt.p1 = pins;
      s_nxt.p2 = s_r.p1;
      s_nxt.port_a_clk_d = s_r.p2.port_a_clk;
      s_nxt.port_b_clk_d = s_r.p2.port_b_clk;
      s_nxt.arready = 1'b1;
      s_nxt.big = s_r.p2.endian_or_fall;
      s_nxt.a_to_b_empty_threshold = thr_def;
      s_nxt.b_to_a_empty_threshold = thr_def;
      s_nxt.a_to_b_full_threshold = thr_def;
      s_nxt.b_to_a_full_threshold = thr_def;
    end
  end

  always_ff @(posedge aclk) begin
    s_r <= s_nxt;
    if (push_ab) begin
      mem_ab[s_r.wab[AW-1:0]] <= s_r.p2.a_data;
    end
    if (push_ba) begin
      mem_ba[s_r.wba[AW-1:0]] <= din_ba;
    end
  end

  assign port_a_near_empty_flag = s_r.fa2[3];
  assign port_a_near_full_flag = s_r.fa2[2];
  assign port_a_empty_or_output_ready = s_r.fa2[1];
  assign port_a_full_or_input_ready = s_r.fa2[0];
  assign port_b_near_empty_flag = s_r.fb2[3];
  assign port_b_near_full_flag = s_r.fb2[2];
  assign port_b_empty_or_output_ready = s_r.fb2[1];
  assign port_b_full_or_input_ready = s_r.fb2[0];
  assign port_a_data_bus_out = s_r.oa;
  assign port_a_data_bus_oe = s_r.oea;
  assign port_b_data_bus_out = s_r.ob;
  assign port_b_data_bus_oe = s_r.oeb;
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rdata = s_r.rdata;
  assign irq = s_r.irq;
endmodule // bfp_top
`default_nettype wire

// ### tb/bfp_port_agent.sv
// Port-side processor model: a free-running port clock and single-beat transfers.
// Assumes the device samples enable and data at the rising port clock edge.
`timescale 1ns/1ps
`default_nettype none
module bfp_port_agent #(
  parameter int HALF_NS = 240
) (
  output logic        pclk,
  output logic        wr_en,
  output logic        rd_en,
  output logic [35:0] data
);
  initial begin
    pclk  = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    data  = 36'h0_0000_0000;
  end
  always #(HALF_NS) pclk = ~pclk;
  // Released data shows the inverse, so a stale word cannot pass for a fresh one.
  task automatic xfer(input logic wr, input logic [35:0] d);
    @(negedge pclk);
    wr_en <= wr;
    rd_en <= ~wr;
    data  <= d;
    @(negedge pclk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    data  <= ~d;
    @(posedge pclk);
  endtask
endmodule // bfp_port_agent
`default_nettype wire

// ### tb/bfp_assertions.sv
// Checker for the queue port controller: register bus, irq and port A pins.
// Assumes it is bound to bfp_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module bfp_assertions (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        port_a_clk,
  input wire logic        port_a_rd_en,
  input wire logic        port_a_data_bus_oe,
  input wire logic        port_a_near_full_flag,
  input wire logic        port_a_near_empty_flag,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic wr_take;
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  write_answer_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  unmapped_write_a: assert property (wr_take && s_axi_awaddr > 8'h23
    |-> ##[1:2] s_axi_bvalid && s_axi_bresp == bfp_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h23
    |=> s_axi_rresp == bfp_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  reset_clear_a: assert property (disable iff (1'b0)
    !aresetn |=> !irq && !s_axi_bvalid && !s_axi_rvalid && !port_a_data_bus_oe)
    else $error("output live in reset");
  irq_mask_a: assert property (wr_take && s_axi_awaddr == bfp_pkg::REG_IRQ_EN
    && s_axi_wdata[3:0] == 4'h0 |-> ##[1:4] !irq)
    else $error("masked irq still high");
  oe_follow_a: assert property (
    $rose(port_a_rd_en) |-> ##[1:4] port_a_data_bus_oe)
    else $error("port A not driven on read");
  flag_edge_a: assert property (
    $changed({port_a_near_full_flag, port_a_near_empty_flag})
    |-> port_a_clk || $past(port_a_clk))
    else $error("port A flag moved off its clock");
endmodule // bfp_assertions
bind bfp_top bfp_assertions i_chk (.aclk, .aresetn, .port_a_clk, .port_a_rd_en,
  .port_a_data_bus_oe, .port_a_near_full_flag, .port_a_near_empty_flag, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
`default_nettype wire

// ### tb/bfp_top_tb_top.sv
// Self-checking bench for the queue port controller with two port agents.
// Assumes a 25 MHz system clock and port clock phases of six aclk or more.
`timescale 1ns/1ps
`default_nettype none
module bfp_top_tb_top;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [1:0]  resp;
  } bfp_row_t;
  localparam logic [35:0] W0 = 36'h1_2345_6789;
  localparam logic [35:0] W1 = 36'hE_DCBA_9876;
  localparam logic [35:0] BW = 36'hA_5C3F_0E71;
  localparam bfp_row_t ROWS [9] = '{
    '{1'b0, bfp_pkg::REG_AE_AB, 32'h0000_0008, bfp_pkg::RESP_OKAY},
    '{1'b1, bfp_pkg::REG_AF_AB, 32'h0000_003D, bfp_pkg::RESP_OKAY},
    '{1'b0, bfp_pkg::REG_AF_AB, 32'h0000_003D, bfp_pkg::RESP_OKAY},
    '{1'b1, bfp_pkg::REG_AE_AB, 32'h0000_0002, bfp_pkg::RESP_OKAY},
    '{1'b0, bfp_pkg::REG_AE_BA, 32'h0000_0008, bfp_pkg::RESP_OKAY},
    '{1'b1, bfp_pkg::REG_COUNT, 32'hFFFF_FFFF, bfp_pkg::RESP_OKAY},
    '{1'b0, bfp_pkg::REG_COUNT, 32'h0000_0000, bfp_pkg::RESP_OKAY},
    '{1'b0, 8'h24, 32'h0000_0000, bfp_pkg::RESP_SLVERR},
    '{1'b1, 8'h24, 32'h0000_0000, bfp_pkg::RESP_SLVERR}
  };
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        endian_or_fall_through_sel = 1'b0;
  logic        port_b_narrow_width_sel = 1'b0;
  logic        port_b_size_sel = 1'b0;
  logic        flag_select_hi = 1'b0;
  logic        flag_select_lo = 1'b0;
  logic        port_a_clk, port_b_clk, port_a_wr_en, port_a_rd_en, port_b_wr_en, port_b_rd_en;
  logic [35:0] a_drv, b_drv, port_a_data_bus_in, port_b_data_bus_in;
  logic [35:0] port_a_data_bus_out, port_b_data_bus_out;
  logic        port_a_data_bus_oe, port_b_data_bus_oe, irq;
  logic        port_a_full_or_input_ready, port_a_empty_or_output_ready;
  logic        port_a_near_full_flag, port_a_near_empty_flag;
  logic        port_b_full_or_input_ready, port_b_empty_or_output_ready;
  logic        port_b_near_full_flag, port_b_near_empty_flag;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int          errors = 0;
  int          samples_checked = 0;
  always #20 aclk = ~aclk;
  bfp_port_agent #(.HALF_NS(240)) i_pa (.pclk(port_a_clk), .wr_en(port_a_wr_en),
    .rd_en(port_a_rd_en), .data(a_drv));
  bfp_port_agent #(.HALF_NS(280)) i_pb (.pclk(port_b_clk), .wr_en(port_b_wr_en),
    .rd_en(port_b_rd_en), .data(b_drv));
  assign port_a_data_bus_in = port_a_data_bus_oe ? port_a_data_bus_out : a_drv;
  assign port_b_data_bus_in = port_b_data_bus_oe ? port_b_data_bus_out : b_drv;
  bfp_top #(.DEPTH(64)) i_dut (
    .aclk, .aresetn, .port_a_clk, .port_b_clk, .port_a_wr_en, .port_a_rd_en,
    .port_b_wr_en, .port_b_rd_en, .endian_or_fall_through_sel, .port_b_narrow_width_sel,
    .port_b_size_sel, .flag_select_hi, .flag_select_lo, .port_a_data_bus_in,
    .port_a_data_bus_out, .port_a_data_bus_oe, .port_b_data_bus_in, .port_b_data_bus_out,
    .port_b_data_bus_oe, .port_a_full_or_input_ready, .port_a_empty_or_output_ready,
    .port_a_near_full_flag, .port_a_near_empty_flag, .port_b_full_or_input_ready,
    .port_b_empty_or_output_ready, .port_b_near_full_flag, .port_b_near_empty_flag,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq
  );
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({35'h0, got}, {35'h0, exp});
  endtask
  task automatic wrap_up;
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awready) ad = 1'b1;
      if (s_axi_wready) wd = 1'b1;
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic do_reset(input logic big, input logic nar, input logic sz,
                          input logic [1:0] fs, input logic tm);
    @(posedge aclk);
    aresetn <= 1'b0;
    endian_or_fall_through_sel <= big;
    port_b_narrow_width_sel <= nar;
    port_b_size_sel <= sz;
    {flag_select_hi, flag_select_lo} <= fs;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    endian_or_fall_through_sel <= tm;
    repeat (4) @(posedge aclk);
  endtask
  // Flags pass two synchronising stages, so give each port three edges.
  task automatic settle;
    repeat (3) @(posedge port_a_clk);
    repeat (3) @(posedge port_b_clk);
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    wrap_up();
  end
  initial begin
    do_reset(1'b1, 1'b1, 1'b1, 2'b01, 1'b1);
    foreach (ROWS[i]) begin
      if (ROWS[i].wr) begin
        axi_wr(ROWS[i].addr, ROWS[i].data, resp);
      end else begin
        axi_rd(ROWS[i].addr, rd, resp);
        chk({4'h0, rd}, {4'h0, ROWS[i].data});
      end
      chk({34'h0, resp}, {34'h0, ROWS[i].resp});
    end
    i_pa.xfer(1'b1, W0);
    i_pa.xfer(1'b1, W1);
    settle();
    chk_bit(port_a_near_full_flag, 1'b1);
    chk_bit(port_b_near_empty_flag, 1'b0);
    chk_bit(port_a_full_or_input_ready, 1'b1);
    i_pa.xfer(1'b1, W0);
    settle();
    chk_bit(port_a_near_full_flag, 1'b0);
    chk_bit(port_b_near_empty_flag, 1'b1);
    // Status bit 1 records the port A near-full fall.
    axi_wr(bfp_pkg::REG_IRQ_EN, 32'h0000_0002, resp);
    repeat (2) @(posedge aclk);
    chk_bit(irq, 1'b1);
    axi_wr(bfp_pkg::REG_IRQ_EN, 32'h0000_0000, resp);
    repeat (2) @(posedge aclk);
    chk_bit(irq, 1'b0);
    axi_wr(bfp_pkg::REG_IRQ_CLR, 32'h0000_0002, resp);
    axi_wr(bfp_pkg::REG_IRQ_EN, 32'h0000_0002, resp);
    repeat (2) @(posedge aclk);
    chk_bit(irq, 1'b0);
    for (int k = 0; k < 4; k++) begin
      i_pb.xfer(1'b0, 36'h0_0000_0000);
      chk(port_b_data_bus_out, {27'h0, W0[35-9*k -: 9]});
    end
    chk_bit(port_b_data_bus_oe, 1'b0);
    for (int k = 0; k < 4; k++) i_pb.xfer(1'b1, {27'h0, BW[35-9*k -: 9]});
    settle();
    chk_bit(port_a_near_empty_flag, 1'b0);
    chk_bit(port_b_near_full_flag, 1'b1);
    chk_bit(port_a_empty_or_output_ready, 1'b1);
    chk_bit(port_b_full_or_input_ready, 1'b1);
    i_pa.xfer(1'b0, 36'h0_0000_0000);
    chk(port_a_data_bus_out, BW);
    do_reset(1'b0, 1'b1, 1'b0, 2'b10, 1'b1);
    axi_rd(bfp_pkg::REG_AE_AB, rd, resp);
    chk({4'h0, rd}, 36'h0_0000_0010);
    i_pa.xfer(1'b1, W0);
    for (int k = 0; k < 2; k++) begin
      i_pb.xfer(1'b0, 36'h0_0000_0000);
      chk(port_b_data_bus_out, {18'h0, W0[18*k +: 18]});
    end
    do_reset(1'b0, 1'b0, 1'b0, 2'b11, 1'b0);
    axi_rd(bfp_pkg::REG_AF_BA, rd, resp);
    chk({4'h0, rd}, 36'h0_0000_0040);
    i_pa.xfer(1'b1, W1);
    settle();
    chk_bit(port_b_empty_or_output_ready, 1'b1);
    chk(port_b_data_bus_out, W1);
    wrap_up();
  end
endmodule // bfp_top_tb_top
`default_nettype wire
